// *** bench/fpct_pulse_src.sv ***
// partner model: external pulse source driving the fast counter pin
`timescale 1ns/1ns
module fpct_pulse_src (
	input  wire logic clk,
	output logic      pin
);
	// the pin idles low between bursts
	initial pin = 1'b0;

	// n pulses, high for hi clocks and low for hi+2 clocks between them
	// hi below 2 would slip past the three-flop synchroniser
	task automatic send(input int n, input int hi);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) pin <= 1'b1;
			repeat (hi) @(posedge clk);
			pin <= 1'b0;
			repeat (hi + 1) @(posedge clk);
		end
	endtask
endmodule // fpct_pulse_src

// *** bench/tb_top.sv ***
// self-checking bench: registers, real-time pin, match, capture
`timescale 1ns/1ns
`include "fpct_regs.svh"
module tb_top
	import fpct_pkg::*;
;
	// byte addresses, four times the register index
	localparam logic [17:0] TC  = {`FPCT_IDX_TIMER_CONTROL, 2'b00};
	localparam logic [17:0] CL  = {`FPCT_IDX_COUNT_LOW, 2'b00};
	localparam logic [17:0] CH  = {`FPCT_IDX_COUNT_HIGH, 2'b00};
	localparam logic [17:0] ML  = {`FPCT_IDX_MATCH_LOW, 2'b00};
	localparam logic [17:0] MH  = {`FPCT_IDX_MATCH_HIGH, 2'b00};
	localparam logic [17:0] CAL = {`FPCT_IDX_CAPTURE_A_LOW, 2'b00};
	localparam logic [17:0] CAH = {`FPCT_IDX_CAPTURE_A_HIGH, 2'b00};
	localparam logic [17:0] CBL = {`FPCT_IDX_CAPTURE_B_LOW, 2'b00};
	localparam logic [17:0] CBH = {`FPCT_IDX_CAPTURE_B_HIGH, 2'b00};
	localparam logic [17:0] PT  = {`FPCT_IDX_PORT_TEST, 2'b00};
	localparam logic [17:0] FC  = {`FPCT_IDX_FAST_CONTROL, 2'b00};
	localparam logic [17:0] BAD = {`FPCT_IDX_TIMER_CONTROL, 2'b01};
	localparam int          LIMIT = 6000; // cycles, about seven and a half times the plan

	// one register access with its expected answer
	typedef struct packed {
		logic        wr;
		logic [17:0] a;
		logic [7:0]  wd;
		logic [7:0]  ex;
		logic        er;
	} fpct_row_type;

	logic             clk     = 1'b0;  // core clock
	logic             rst_b   = 1'b0;  // reset, active low
	logic             psel    = 1'b0;  // apb select
	logic             penable = 1'b0;  // apb access phase
	logic             pwrite  = 1'b0;  // apb direction
	logic [17:0]      paddr   = '0;    // apb byte address
	logic [31:0]      pwdata  = '0;    // apb write data
	logic [31:0]      prdata;          // apb read data
	logic             pready;          // apb answer
	logic             pslverr;         // apb error
	logic             tick    = 1'b0;  // prescaler match pulse
	fpct_capture_type capEvt  = '0;    // capture detector pulses
	logic             fastPin;         // fast pulse pin from partner
	logic             latch   = 1'b0;  // port latch bit
	logic             rtOut;           // real-time pin, only ever an output here
	logic             highIrq;         // high interrupt
	logic             lowIrq;          // low interrupt
	int               errCount   = 0;  // mismatches
	int               checksDone = 0;  // comparisons
	int               cycles     = 0;  // timeout counter
	logic [31:0]      rd;              // last read data
	logic             er;              // last error flag
	fpct_row_type     rows [0:27] = '{
		'{0,TC,8'h00,8'h00,0}, '{0,CL,8'h00,8'h00,0}, '{0,CH,8'h00,8'h00,0},
		'{0,CAL,8'h00,8'h00,0}, '{0,CAH,8'h00,8'h00,0}, '{0,CBL,8'h00,8'h00,0},
		'{0,CBH,8'h00,8'h00,0}, '{0,FC,8'h00,8'h00,0}, '{0,PT,8'h00,8'h00,0},
		'{0,ML,8'h00,8'h00,0}, '{0,MH,8'h00,8'h00,0}, '{1,ML,8'hA5,8'h00,0},
		'{0,ML,8'h00,8'hA5,0}, '{1,MH,8'h3C,8'h00,0}, '{0,MH,8'h00,8'h3C,0},
		'{1,CL,8'h77,8'h00,0}, '{0,CL,8'h00,8'h00,0}, '{1,CAL,8'h11,8'h00,0},
		'{0,CAL,8'h00,8'h00,0}, '{1,PT,8'hFF,8'h00,0}, '{0,PT,8'h00,8'h04,0},
		'{1,PT,8'h00,8'h00,0}, '{1,FC,8'hFF,8'h00,0}, '{0,FC,8'h00,8'hF0,0},
		'{1,FC,8'h00,8'h00,0}, '{0,18'h0,8'h00,8'h00,1}, '{1,18'h0,8'h12,8'h00,1},
		'{0,BAD,8'h00,8'h00,1}};

	// 100 MHz clock
	always #5 clk = ~clk;

	fpct_top i_fpct_top (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prescalerTick(tick), .captureEvt(capEvt),
		.fastPulseInput(fastPin), .portLatch(latch), .realtimeOut(rtOut),
		.highIrq(highIrq), .lowIrq(lowIrq)
	);

	fpct_pulse_src i_fpct_pulse_src (
		.clk(clk),
		.pin(fastPin)
	);

	// counts and verdict, the one place the run ends
	task automatic summarize();
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errCount++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			errCount++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// setup, access, hold until pready is sampled high
	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [17:0] a, input logic [7:0] ex);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h0, ex});
	endtask

	// wait for the pin to go high, bounded
	task automatic waitPin();
		for (int i = 0; i < 40 && rtOut !== 1'b1; i++) @(posedge clk);
		cyc(6);
	endtask

	initial begin
		cyc(10);
		rst_b <= 1'b1;
		cyc(3);
		// reset values, access kinds, refused addresses
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].wd);
			chk({31'h0, er}, {31'h0, rows[i].er});
			if (!rows[i].wr) chk(rd, {24'h0, rows[i].ex});
		end
		$display("register rows done");
		// pin is a plain port while disabled
		latch <= 1'b1;
		cyc(4);
		chk({31'h0, rtOut}, 32'h1);
		apb(1'b1, PT, 8'h04);
		apb(1'b1, FC, 8'hA0);
		latch <= 1'b0;
		cyc(4);
		chk({31'h0, rtOut}, 32'h0);
		apb(1'b1, PT, 8'h00);
		apb(1'b1, FC, 8'h00);
		$display("port pin done");
		// target (1+1)*8+2 = 18 pulses, 11-bit mode
		apb(1'b1, ML, 8'h01);
		apb(1'b1, FC, 8'hA0);
		latch <= 1'b1;
		cyc(4);
		chk({31'h0, rtOut}, 32'h0);
		apb(1'b1, TC, 8'h51);
		i_fpct_pulse_src.send(17, 3);
		cyc(8);
		chk({30'h0, rtOut, lowIrq}, 32'h0);
		i_fpct_pulse_src.send(1, 5);
		waitPin();
		chk({30'h0, rtOut, lowIrq}, 32'h3);
		rdc(TC, 8'h53);
		rdc(CL, 8'h02);
		// one match only until the fast control is rewritten
		latch <= 1'b0;
		apb(1'b1, TC, 8'h51);
		apb(1'b1, ML, 8'h03);
		cyc(4);
		chk({31'h0, rtOut}, 32'h0);
		i_fpct_pulse_src.send(16, 3);
		cyc(8);
		rdc(TC, 8'h51);
		// rearm for target 50 with the interrupt masked
		apb(1'b1, ML, 8'h05);
		apb(1'b1, TC, 8'h50);
		apb(1'b1, FC, 8'hA0);
		latch <= 1'b1;
		i_fpct_pulse_src.send(16, 4);
		waitPin();
		chk({30'h0, rtOut, lowIrq}, 32'h2);
		rdc(TC, 8'h52);
		apb(1'b1, TC, 8'h53);
		cyc(2);
		chk({31'h0, lowIrq}, 32'h1);
		apb(1'b1, TC, 8'h51);
		cyc(2);
		chk({31'h0, lowIrq}, 32'h0);
		$display("match done");
		// count 50: low byte 6, fast field 2, no carry
		@(posedge clk) capEvt <= 4'b1010;
		@(posedge clk) capEvt <= 4'b0000;
		cyc(4);
		rdc(FC, 8'hA2);
		rdc(CAL, 8'h06);
		rdc(CBL, 8'h06);
		// high byte on prescaler ticks
		apb(1'b1, TC, 8'hD1);
		repeat (5) begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 1'b0;
		end
		cyc(2);
		rdc(CH, 8'h05);
		@(posedge clk) capEvt <= 4'b0101;
		@(posedge clk) capEvt <= 4'b0000;
		cyc(4);
		rdc(CAH, 8'h05);
		rdc(CBH, 8'h05);
		$display("capture done");
		// plain sixteen-bit mode on prescaler ticks, match at 0x0003
		apb(1'b1, FC, 8'h00);
		apb(1'b1, TC, 8'h00);
		apb(1'b1, ML, 8'h03);
		apb(1'b1, MH, 8'h00);
		apb(1'b1, TC, 8'hE4);
		repeat (3) begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 1'b0;
		end
		cyc(2);
		rdc(TC, 8'hE4);
		chk({31'h0, highIrq}, 32'h0);
		@(posedge clk) tick <= 1'b1;
		@(posedge clk) tick <= 1'b0;
		cyc(2);
		chk({31'h0, highIrq}, 32'h1);
		rdc(TC, 8'hEE);
		rdc(CL, 8'h00);
		$display("wide match done");
		// reset in mid-run clears state
		rst_b <= 1'b0;
		cyc(3);
		chk({29'h0, rtOut, lowIrq, highIrq}, 32'h0);
		rst_b <= 1'b1;
		cyc(4);
		rdc(TC, 8'h00);
		rdc(CL, 8'h00);
		$display("reset done");
		summarize();
	end
endmodule // tb_top

// *** hw/fpct_pkg.sv ***
// types shared by the fast counter timer
package fpct_pkg;
	// capture detection pulses from the external input detectors
	typedef struct packed {
		logic aLow;
		logic aHigh;
		logic bLow;
		logic bHigh;
	} fpct_capture_type;

	// complete state of the block except the reset synchroniser
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  countLow;
		logic [7:0]  countHigh;
		logic [7:0]  dataLow;
		logic [7:0]  dataHigh;
		logic [7:0]  bufLow;
		logic [7:0]  bufHigh;
		logic [7:0]  capALow;
		logic [7:0]  capAHigh;
		logic [7:0]  capBLow;
		logic [7:0]  capBHigh;
		logic        rtDisable;
		logic        fcEnable;
		logic [2:0]  fcCompare;
		logic        capCarry;
		logic [2:0]  capCount;
		logic [2:0]  fastCnt;
		logic        armed;
		logic        rtPin;
		logic [2:0]  pinSync;
		logic        pinLevel;
		logic        irqHigh;
		logic        irqLow;
		logic        ready;
		logic [31:0] rdata;
		logic        slverr;
	} fpct_state_type;
endpackage

// *** hw/fpct_regs.svh ***
// register indices, field positions and reset values of the fast counter timer
// What this block does
// - high byte ticks on prescaler or low overflow
// - low match buffer mirrors or reloads on match
// - high match buffer mirrors or reloads on match
// - wide mode matches all sixteen bits
// - four capture registers latch counts, read-only
// - three-bit fast counter counts pin pulses
// - coupled timer counts fast overflows, free-running
// - eleven or nineteen bit combined counter
// - fast counter runs with low byte
// - match at (match+1)*8+compare sets flag
// - on match pin takes prepared latch value
// - one match only until fast control rewritten
// - enable low makes pin follow latch
// - enabling write re-arms and holds pin
// - disable bit reverts pin to port
// - capture fast count plus carry with capture A low
// - control register field layout, capture read-only
// - flags stick, with enable raise interrupt
`ifndef FPCT_REGS_SVH
`define FPCT_REGS_SVH
// register indices; byte address is four times the index
`define FPCT_IDX_TIMER_CONTROL    16'hFE10
`define FPCT_IDX_COUNT_LOW        16'hFE12
`define FPCT_IDX_COUNT_HIGH       16'hFE13
`define FPCT_IDX_MATCH_LOW        16'hFE14
`define FPCT_IDX_MATCH_HIGH       16'hFE15
`define FPCT_IDX_CAPTURE_A_LOW    16'hFE16
`define FPCT_IDX_CAPTURE_A_HIGH   16'hFE17
`define FPCT_IDX_CAPTURE_B_LOW    16'hFE1E
`define FPCT_IDX_CAPTURE_B_HIGH   16'hFE1F
`define FPCT_IDX_PORT_TEST        16'hFE47
`define FPCT_IDX_FAST_CONTROL     16'hFE7D
// timer control bits
`define FPCT_BIT_HIGH_RUN         7
`define FPCT_BIT_LOW_RUN          6
`define FPCT_BIT_WIDE             5
`define FPCT_BIT_LOW_EXT          4
`define FPCT_BIT_HIGH_FLAG        3
`define FPCT_BIT_HIGH_IE          2
`define FPCT_BIT_LOW_FLAG         1
`define FPCT_BIT_LOW_IE           0
// fast counter control and port test bits
`define FPCT_BIT_FAST_ENABLE      7
`define FPCT_BIT_RT_DISABLE       2
// reset values
`define FPCT_RST_BYTE             8'h00
`define FPCT_RST_FAST             3'h0
`endif

// *** hw/fpct_top.sv ***
// fast prescount timer with capture and real-time output, APB slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "fpct_regs.svh"
module fpct_top
	import fpct_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              prescalerTick,
	input  wire fpct_capture_type  captureEvt,
	input  wire logic              fastPulseInput,
	input  wire logic              portLatch,
	output logic                   realtimeOut,
	output logic                   highIrq,
	output logic                   lowIrq
);
	// register index hit test, used by read and write decode
	function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
		regHit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	fpct_state_type s;            // registered state
	fpct_state_type n;            // next state
	logic [1:0]     rstSync;      // reset release synchroniser
	logic           rstN;         // synchronised reset
	logic           lowRun;       // low byte running
	logic           highRun;      // high byte running
	logic           wide;         // sixteen-bit mode
	logic           coupled;      // fast counter enabled
	logic           pulse;        // filtered rising edge of fast pin
	logic           fastRun;      // fast counter counting
	logic           fastOvf;      // fast counter wraps this cycle
	logic           lowTick;      // low byte count clock
	logic           highTick;     // high byte count clock
	logic           lowMatch8;    // eight-bit low match
	logic           highMatch8;   // eight-bit high match
	logic           wideMatch;    // sixteen-bit match
	logic           fastMatch;    // combined counter hit target
	logic [11:0]    target11;     // eleven-bit target, one spare bit
	logic [19:0]    target19;     // nineteen-bit target, one spare bit
	logic           lowSet;       // low flag set event
	logic           highSet;      // high flag set event
	logic           wrEn;         // write takes effect
	logic           rdLoad;       // read data prepared
	logic           armWrite;     // enabling control write

	// reset release through two flip-flops; only constants under async reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// control decode
	assign lowRun  = s.ctrl[`FPCT_BIT_LOW_RUN];
	assign highRun = s.ctrl[`FPCT_BIT_HIGH_RUN];
	assign wide    = s.ctrl[`FPCT_BIT_WIDE];
	assign coupled = s.fcEnable;
	// a change counts once the second and third stages agree
	assign pulse   = s.pinSync[1] && s.pinSync[2] && !s.pinLevel;
	assign fastRun = coupled && lowRun;
	assign fastOvf = fastRun && pulse && (s.fastCnt == 3'h7);
	// coupled low byte counts only fast overflows; otherwise pin or prescaler
	assign lowTick = coupled ? fastOvf
		: (s.ctrl[`FPCT_BIT_LOW_EXT] ? pulse : prescalerTick);
	// high byte clock follows the width mode
	assign highTick = wide ? (lowTick && (s.countLow == 8'hFF)) : prescalerTick;
	// ordinary matches; coupled counters never reset on match
	assign lowMatch8  = !coupled && !wide && lowRun && lowTick && (s.countLow == s.bufLow);
	assign highMatch8 = !wide && highRun && highTick && (s.countHigh == s.bufHigh);
	assign wideMatch  = !coupled && wide && lowRun && lowTick
		&& ({s.countHigh, s.countLow} == {s.bufHigh, s.bufLow});
	// target is (match+1)*8 + compare; spare top bit keeps an overflowed target unreachable
	assign target11 = {({1'b0, s.dataLow} + 9'h001), s.fcCompare};
	assign target19 = {({1'b0, s.dataHigh, s.dataLow} + 17'h00001), s.fcCompare};
	assign fastMatch = s.armed && fastRun && (wide
		? ({1'b0, s.countHigh, s.countLow, s.fastCnt} == target19)
		: ({1'b0, s.countLow, s.fastCnt} == target11));
	// flags set together in wide mode
	assign lowSet  = lowMatch8 || wideMatch || fastMatch;
	assign highSet = highMatch8 || wideMatch || (fastMatch && wide);
	// apb strobes: one wait state, write lands at the completing edge
	assign wrEn     = psel && penable && pwrite && s.ready;
	assign rdLoad   = psel && penable && !s.ready;
	assign armWrite = wrEn && regHit(paddr, `FPCT_IDX_FAST_CONTROL)
		&& pwdata[`FPCT_BIT_FAST_ENABLE];

	// next-state logic
	always_comb begin
		n = s;
		// pin synchroniser and filtered level
		n.pinSync = {s.pinSync[1:0], fastPulseInput};
		if (s.pinSync[1] == s.pinSync[2]) begin
			n.pinLevel = s.pinSync[2];
		end
		// fast counter stops and clears with the low byte
		if (!fastRun) begin
			n.fastCnt = `FPCT_RST_FAST;
		end else if (pulse) begin
			n.fastCnt = s.fastCnt + 3'h1;
		end
		// low byte: held at zero while stopped, resets on its own match
		if (!lowRun) begin
			n.countLow = `FPCT_RST_BYTE;
		end else if (lowTick) begin
			if (lowMatch8 || wideMatch) begin
				n.countLow = `FPCT_RST_BYTE;
			end else begin
				n.countLow = s.countLow + 8'h01;
			end
		end
		// high byte
		if (!highRun) begin
			n.countHigh = `FPCT_RST_BYTE;
		end else if (wideMatch || highMatch8) begin
			n.countHigh = `FPCT_RST_BYTE;
		end else if (highTick) begin
			n.countHigh = s.countHigh + 8'h01;
		end
		// match buffers mirror while stopped, reload on match while running
		if (!lowRun || lowMatch8 || wideMatch) begin
			n.bufLow = s.dataLow;
		end
		if (!highRun || highMatch8 || wideMatch) begin
			n.bufHigh = s.dataHigh;
		end
		// captures; fast state is taken with the capture A low byte
		if (captureEvt.aLow) begin
			n.capALow  = s.countLow;
			n.capCarry = fastOvf;
			n.capCount = (fastRun && pulse) ? s.fastCnt + 3'h1 : s.fastCnt;
		end
		if (captureEvt.aHigh) begin
			n.capAHigh = s.countHigh;
		end
		if (captureEvt.bLow) begin
			n.capBLow = s.countLow;
		end
		if (captureEvt.bHigh) begin
			n.capBHigh = s.countHigh;
		end
		// register writes
		if (wrEn) begin
			if (regHit(paddr, `FPCT_IDX_TIMER_CONTROL)) begin
				n.ctrl = pwdata[7:0];
			end else if (regHit(paddr, `FPCT_IDX_MATCH_LOW)) begin
				n.dataLow = pwdata[7:0];
			end else if (regHit(paddr, `FPCT_IDX_MATCH_HIGH)) begin
				n.dataHigh = pwdata[7:0];
			end else if (regHit(paddr, `FPCT_IDX_PORT_TEST)) begin
				n.rtDisable = pwdata[`FPCT_BIT_RT_DISABLE];
			end else if (regHit(paddr, `FPCT_IDX_FAST_CONTROL)) begin
				// capture bits are read-only
				n.fcEnable  = pwdata[`FPCT_BIT_FAST_ENABLE];
				n.fcCompare = pwdata[6:4];
			end
		end
		// set wins over a software clear in the same cycle
		if (lowSet) begin
			n.ctrl[`FPCT_BIT_LOW_FLAG] = 1'b1;
		end
		if (highSet) begin
			n.ctrl[`FPCT_BIT_HIGH_FLAG] = 1'b1;
		end
		n.irqLow  = n.ctrl[`FPCT_BIT_LOW_FLAG] && n.ctrl[`FPCT_BIT_LOW_IE];
		n.irqHigh = n.ctrl[`FPCT_BIT_HIGH_FLAG] && n.ctrl[`FPCT_BIT_HIGH_IE];
		// arming: any fast control write decides; a match disarms
		if (wrEn && regHit(paddr, `FPCT_IDX_FAST_CONTROL)) begin
			n.armed = pwdata[`FPCT_BIT_FAST_ENABLE];
		end else if (fastMatch) begin
			n.armed = 1'b0;
		end
		// real-time pin; the pin is a flop, so it moves on the core edge
		if (armWrite && !s.rtDisable) begin
			n.rtPin = s.rtPin;
		end else if (s.fcEnable && !s.rtDisable && s.armed) begin
			if (fastMatch) begin
				n.rtPin = portLatch;
			end
		end else begin
			n.rtPin = portLatch;
		end
		// apb answer, prepared one cycle before pready
		n.ready = rdLoad;
		if (rdLoad) begin
			n.slverr = 1'b0;
			if (regHit(paddr, `FPCT_IDX_TIMER_CONTROL)) begin
				n.rdata = {24'h000000, s.ctrl};
			end else if (regHit(paddr, `FPCT_IDX_COUNT_LOW)) begin
				n.rdata = {24'h000000, s.countLow};
			end else if (regHit(paddr, `FPCT_IDX_COUNT_HIGH)) begin
				n.rdata = {24'h000000, s.countHigh};
			end else if (regHit(paddr, `FPCT_IDX_MATCH_LOW)) begin
				n.rdata = {24'h000000, s.dataLow};
			end else if (regHit(paddr, `FPCT_IDX_MATCH_HIGH)) begin
				n.rdata = {24'h000000, s.dataHigh};
			end else if (regHit(paddr, `FPCT_IDX_CAPTURE_A_LOW)) begin
				n.rdata = {24'h000000, s.capALow};
			end else if (regHit(paddr, `FPCT_IDX_CAPTURE_A_HIGH)) begin
				n.rdata = {24'h000000, s.capAHigh};
			end else if (regHit(paddr, `FPCT_IDX_CAPTURE_B_LOW)) begin
				n.rdata = {24'h000000, s.capBLow};
			end else if (regHit(paddr, `FPCT_IDX_CAPTURE_B_HIGH)) begin
				n.rdata = {24'h000000, s.capBHigh};
			end else if (regHit(paddr, `FPCT_IDX_PORT_TEST)) begin
				n.rdata = {29'h00000000, s.rtDisable, 2'h0};
			end else if (regHit(paddr, `FPCT_IDX_FAST_CONTROL)) begin
				n.rdata = {24'h000000, s.fcEnable, s.fcCompare, s.capCarry, s.capCount};
			end else begin
				// unmapped: zero data and an error
				n.rdata  = 32'h00000000;
				n.slverr = 1'b1;
			end
		end
	end

	// state register; reset takes constants only
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// outputs straight from flops
	assign prdata      = s.rdata;
	assign pready      = s.ready;
	assign pslverr     = s.slverr;
	assign realtimeOut = s.rtPin;
	assign highIrq     = s.irqHigh;
	assign lowIrq      = s.irqLow;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	sequence seqArm;
		armWrite && !s.rtDisable;
	endsequence
	sequence seqHit;
		fastMatch && s.fcEnable && !s.rtDisable;
	endsequence

	buf_low_mirror_a: assert property (!lowRun |=> s.bufLow == $past(s.dataLow))
		else $error("low match buffer not mirroring");
	buf_high_mirror_a: assert property (!highRun |=> s.bufHigh == $past(s.dataHigh))
		else $error("high match buffer not mirroring");
	wide_match_a: assert property (wideMatch |=> s.countLow == 8'h00 && s.countHigh == 8'h00
		&& s.ctrl[`FPCT_BIT_LOW_FLAG] && s.ctrl[`FPCT_BIT_HIGH_FLAG])
		else $error("wide match did not reset both bytes");
	capture_low_a: assert property (captureEvt.aLow |=> s.capALow == $past(s.countLow))
		else $error("low capture wrong");
	fast_count_a: assert property (fastRun && pulse |=> s.fastCnt == $past(s.fastCnt) + 3'h1)
		else $error("fast counter did not advance");
	free_run_a: assert property (coupled && lowRun && fastOvf |=>
		s.countLow == $past(s.countLow) + 8'h01)
		else $error("coupled low byte did not count overflow");
	low_stop_a: assert property (!lowRun |=> s.countLow == 8'h00 && s.fastCnt == 3'h0)
		else $error("stopped counters not cleared");
	match_once_a: assert property (fastMatch |=> !s.armed && s.ctrl[`FPCT_BIT_LOW_FLAG]
		##1 !fastMatch[*2])
		else $error("match repeated or flag missing");
	rt_fire_a: assert property (seqHit |=> s.rtPin == $past(portLatch))
		else $error("real-time pin did not take value");
	rt_hold_a: assert property (seqArm |=> $stable(s.rtPin))
		else $error("arming write moved the pin");
	// an arming write holds the pin instead, and the reset edge itself is left out
	rt_plain_a: assert property (rstN && !(armWrite && !s.rtDisable)
		&& (!s.fcEnable || s.rtDisable) |=> s.rtPin == $past(portLatch))
		else $error("pin not following latch");
	irq_low_a: assert property (s.ctrl[`FPCT_BIT_LOW_FLAG] && s.ctrl[`FPCT_BIT_LOW_IE]
		|-> lowIrq)
		else $error("low interrupt missing");
endmodule // fpct_top
